// File: bench/lfs_master_model.sv
// Far-end line master model driving the comm line
`default_nettype none

module lfs_master_model (
	input wire logic clock,
	input wire logic force_wake,
	input wire logic tx_level,
	output logic line_level
);
	// Line follows our driver unless the master overdrives it
	always_ff @(posedge clock) begin
		line_level <= force_wake ? ~tx_level : tx_level;
	end
endmodule

`default_nettype wire

// File: bench/lfs_tb_top.sv
// Self-checking bench of the line fault supervisor
`default_nettype none

`define CHK(n, e, g) begin \
	checks++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("FAIL %s exp %0h got %0h", n, e, g); \
	end \
end

module lfs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clock, rst_b, reg_wr, reg_rd, force_wake, ext_n, line;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic comm_on, aux_on, alert_n, wake_n, pin_out, pin_oe, reg_en, ser_en;
	logic [1:0] cl_sel;
	lfs_pkg::lfs_sense_s s, sn;
	int num_errors, checks, cyc;
	logic [31:0] rnd = 32'h439d;

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [1:0] exp_cl(input logic [7:0] cfg);
		return cfg[1:0];
	endfunction

	// Pin is pulled up; low if we or the host pull it
	always_comb begin
		sn = s;
		sn.comm_line_level = line;
		sn.reset_pin_level = ~pin_oe & ext_n;
	end

	// Shortened counts keep the run brief
	lfs_top #(
		.BLANK_CYC({24'h50, 24'h3c, 24'h28, 24'h14}),
		.OFF_CYC({24'h5a, 24'h46, 24'h32, 24'h1e}),
		.WAKE_PULSE_CYC(24'h10),
		.HOLD_CYC(24'h28)
	) u_lfs_top (
		.clock(clock), .rst_b(rst_b), .sense(sn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.comm_drive_on(comm_on), .aux_drive_on(aux_on),
		.current_limit_select(cl_sel), .alert_n(alert_n),
		.wake_pulse_n(wake_n), .reset_pin_out(pin_out),
		.reset_pin_oe(pin_oe), .regulators_enable(reg_en),
		.serial_enable(ser_en)
	);

	lfs_master_model u_lfs_master_model (
		.clock(clock), .force_wake(force_wake),
		.tx_level(s.comm_tx_level), .line_level(line)
	);

	// ----
	// Tasks
	// ----
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic span(input logic lvl, output int k);
		k = 0;
		#1;
		while (aux_on !== lvl && k < 500) begin
			@(posedge clock);
			#1 k++;
		end
	endtask

	task automatic flt(input logic [4:0] f);
		s.field_supply_low <= f[0];
		s.five_volt_rail_low <= f[1];
		s.logic_supply_low <= f[2];
		s.buck_low <= f[3];
		s.die_shutdown <= f[4];
	endtask

	task automatic stop_test();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Hang guard, far above the expected run
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	// ----
	// Scenarios
	// ----
	initial begin
		logic [7:0] d, q;
		int n;
		rst_b = 1'b0;
		s = '0;
		ext_n = 1'b1;
		force_wake = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		repeat (12) @(posedge clock);
		for (int a = 0; a < 3; a++) begin
			rd(4'(a), d);
			`CHK("reset value", 8'h00, d)
		end
		rd(4'hf, d);
		`CHK("unmapped", 8'h00, d)
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			s.comm_tx_level <= rnd[7];
			d = {1'b0, rnd[6:2], 2'(k)};
			wr(lfs_pkg::ADDR_CURRENT_LIMIT, d);
			rd(lfs_pkg::ADDR_CURRENT_LIMIT, q);
			`CHK("config", d, q)
			`CHK("limit select", exp_cl(d), cl_sel)
		end
		wr(lfs_pkg::ADDR_CURRENT_LIMIT, 8'h00);
		wr(lfs_pkg::ADDR_CONTROL, 8'h01);
		s.driver_enable_in <= 1'b1;
		repeat (6) @(posedge clock);
		#1 `CHK("comm on", 1'b1, comm_on)
		s.overcurrent[0] <= 1'b1;
		repeat (30) @(posedge clock);
		#1 `CHK("comm kept", 1'b1, comm_on)
		`CHK("alert", 1'b0, alert_n)
		rd(lfs_pkg::ADDR_STATUS, d);
		`CHK("status", 8'h01, d)
		s.overcurrent[0] <= 1'b0;
		rd(lfs_pkg::ADDR_INTERRUPT, d);
		`CHK("events", 8'h01, d)
		rd(lfs_pkg::ADDR_INTERRUPT, d);
		`CHK("cleared", 8'h00, d)
		`CHK("alert off", 1'b1, alert_n)
		// Retry with 40 cycle blanking and 30 cycle off-time
		wr(lfs_pkg::ADDR_CURRENT_LIMIT, 8'h44);
		s.overcurrent[1] <= 1'b1;
		span(1'b0, n);
		`CHK("retry blank", 1'b1, n inside {[38:48]})
		span(1'b1, n);
		`CHK("retry off", 1'b1, n inside {[28:34]})
		span(1'b0, n);
		`CHK("retry on", 1'b1, n inside {[38:46]})
		s.overcurrent[1] <= 1'b0;
		repeat (60) @(posedge clock);
		rd(lfs_pkg::ADDR_INTERRUPT, d);
		`CHK("aux event", 8'h02, d)
		wr(lfs_pkg::ADDR_CURRENT_LIMIT, 8'h00);
		s.driver_hot[1] <= 1'b1;
		for (int j = 0; j < 8; j++) begin
			@(posedge clock);
			#1 `CHK("alert held", 1'b1, alert_n)
		end
		`CHK("hot off", 1'b0, aux_on)
		repeat (25) @(posedge clock);
		#1 `CHK("hot alert", 1'b0, alert_n)
		s.driver_hot[1] <= 1'b0;
		s.driver_cool[1] <= 1'b1;
		repeat (8) @(posedge clock);
		#1 `CHK("cooled", 1'b1, aux_on)
		rd(lfs_pkg::ADDR_INTERRUPT, d);
		`CHK("hot event", 8'h02, d)
		s.driver_cool[1] <= 1'b0;
		wr(lfs_pkg::ADDR_ALERT_MASK, 8'h08);
		s.die_warn <= 1'b1;
		repeat (6) @(posedge clock);
		#1 `CHK("masked", 1'b1, alert_n)
		rd(lfs_pkg::ADDR_STATUS, d);
		`CHK("warn state", 8'h08, d)
		rd(lfs_pkg::ADDR_INTERRUPT, d);
		`CHK("warn event", 8'h08, d)
		s.die_warn <= 1'b0;
		wr(lfs_pkg::ADDR_ALERT_MASK, 8'h00);
		wr(lfs_pkg::ADDR_CONTROL, 8'h03);
		force_wake <= 1'b1;
		repeat (3300) @(posedge clock);
		#1 `CHK("wake off", 1'b1, wake_n)
		force_wake <= 1'b0;
		wr(lfs_pkg::ADDR_CONTROL, 8'h01);
		repeat (30) @(posedge clock);
		force_wake <= 1'b1;
		n = 0;
		while (wake_n !== 1'b0 && n < 4000) begin
			@(posedge clock);
			#1 n++;
		end
		`CHK("wake delay", 1'b1, n inside {[3200:3210]})
		force_wake <= 1'b0;
		repeat (20) @(posedge clock);
		#1 `CHK("wake alert", 1'b0, alert_n)
		rd(lfs_pkg::ADDR_INTERRUPT, d);
		`CHK("wake event", 8'h04, d)
		// Fresh driver edge: detection must wait out the blanking first
		s.comm_tx_level <= ~s.comm_tx_level;
		force_wake <= 1'b1;
		n = 0;
		while (wake_n !== 1'b0 && n < 4000) begin
			@(posedge clock);
			#1 n++;
		end
		`CHK("wake blanked", 1'b1, n inside {[3218:3230]})
		force_wake <= 1'b0;
		for (int b = 1; b >= 0; b--) begin
			wr(lfs_pkg::ADDR_CONTROL, 8'h01);
			wr(lfs_pkg::ADDR_MODE, 8'(b));
			ext_n <= 1'b0;
			repeat (8) @(posedge clock);
			#1 `CHK("pin low drive", 1'b0, comm_on)
			rd(lfs_pkg::ADDR_CONTROL, d);
			`CHK("held default", 8'h00, d)
			rd(lfs_pkg::ADDR_MODE, d);
			`CHK("mode kept", 8'(b), d)
			ext_n <= 1'b1;
			repeat (4) @(posedge clock);
			#1 `CHK("hold start", 1'(b), pin_oe)
			n = 0;
			while (pin_oe !== 1'b0 && n < 200) begin
				@(posedge clock);
				#1 n++;
			end
			`CHK("hold", 1'b1, b ? n inside {[38:48]} : n < 8)
			repeat (10) @(posedge clock);
		end
		for (int k = 0; k < 5; k++) begin
			wr(lfs_pkg::ADDR_CURRENT_LIMIT, 8'h03);
			flt(5'(1 << k));
			repeat (8) @(posedge clock);
			#1 `CHK("drives off", 2'b00, {comm_on, aux_on})
			`CHK("regulators", 1'(k != 4), reg_en)
			`CHK("serial", 1'(k != 4), ser_en)
			flt(5'h00);
			repeat (20) @(posedge clock);
			rd(lfs_pkg::ADDR_CURRENT_LIMIT, d);
			`CHK("regs reset", (k == 2) ? 8'h03 : 8'h00, d)
		end
		stop_test();
	end
endmodule

`default_nettype wire

// File: bench/lfs_top_properties.sv
// Port checks of the line fault supervisor
`default_nettype none

module lfs_top_properties #(
	parameter logic [lfs_pkg::CNT_W-1:0] WAKE_PULSE_CYC = 24'h10
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire lfs_pkg::lfs_sense_s sense,
	input wire logic comm_drive_on,
	input wire logic aux_drive_on,
	input wire logic alert_n,
	input wire logic wake_pulse_n,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	input wire logic regulators_enable,
	input wire logic serial_enable
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	// ----
	// Helper
	// ----
	// Length of the wake pulse, too long for a repetition
	logic [lfs_pkg::CNT_W-1:0] low_cnt;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			low_cnt <= '0;
		else if (wake_pulse_n)
			low_cnt <= '0;
		else
			low_cnt <= low_cnt + 1'b1;
	end

	// ----
	// Properties
	// ----
	// Five samples cover two sync flops and the output flop
	property p_uv_off;
		sense.field_supply_low [*5] |-> !comm_drive_on && !aux_drive_on;
	endproperty
	property p_uv_pin;
		sense.five_volt_rail_low [*5] |-> reset_pin_oe;
	endproperty
	property p_buck_pin;
		sense.buck_low [*5] |-> reset_pin_oe && !aux_drive_on;
	endproperty
	property p_die_off;
		sense.die_shutdown [*5] |->
			!regulators_enable && reset_pin_oe && !aux_drive_on;
	endproperty
	property p_serial_off;
		(sense.die_shutdown && !sense.five_volt_external) [*5] |->
			!serial_enable;
	endproperty
	property p_pin_low_off;
		!sense.reset_pin_level [*5] |-> !comm_drive_on && !aux_drive_on;
	endproperty
	property p_comm_gate;
		!sense.driver_enable_in [*5] |-> !comm_drive_on;
	endproperty
	property p_hot_off;
		sense.driver_hot[1] [*5] |-> !aux_drive_on;
	endproperty
	property p_wake_len;
		$rose(wake_pulse_n) |-> low_cnt == WAKE_PULSE_CYC;
	endproperty
	property p_open_drain;
		reset_pin_out == 1'b0;
	endproperty

	a_uv_off: assert property (p_uv_off)
		else $error("drivers on during undervoltage");
	a_uv_pin: assert property (p_uv_pin)
		else $error("reset pin free during rail undervoltage");
	a_buck_pin: assert property (p_buck_pin)
		else $error("reset pin free with buck low");
	a_die_off: assert property (p_die_off)
		else $error("die shutdown did not stop outputs");
	a_serial_off: assert property (p_serial_off)
		else $error("serial port alive in die shutdown");
	a_pin_low_off: assert property (p_pin_low_off)
		else $error("drivers on while reset pin low");
	a_comm_gate: assert property (p_comm_gate)
		else $error("comm driver on without enable input");
	a_hot_off: assert property (p_hot_off)
		else $error("aux driver on while hot");
	a_wake_len: assert property (p_wake_len)
		else $error("wake pulse length wrong");
	a_open_drain: assert property (p_open_drain)
		else $error("reset pin driven high");

	c_wake: cover property ($fell(wake_pulse_n));
	c_alert: cover property ($fell(alert_n));
	c_hold: cover property ($fell(reset_pin_oe));
endmodule

bind lfs_top lfs_top_properties #(
	.WAKE_PULSE_CYC(WAKE_PULSE_CYC)
) u_lfs_top_properties (
	.clock(clock),
	.rst_b(rst_b),
	.sense(sense),
	.comm_drive_on(comm_drive_on),
	.aux_drive_on(aux_drive_on),
	.alert_n(alert_n),
	.wake_pulse_n(wake_pulse_n),
	.reset_pin_out(reset_pin_out),
	.reset_pin_oe(reset_pin_oe),
	.regulators_enable(regulators_enable),
	.serial_enable(serial_enable)
);

`default_nettype wire

// File: hdl/lfs_pkg.sv
// Constants, carrier structs and state types of the line fault supervisor
`default_nettype none

package lfs_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int CNT_W = 24;
	localparam int BLANK_NS_0 = 128000;
	localparam int BLANK_NS_1 = 500000;
	localparam int BLANK_NS_2 = 1000000;
	localparam int BLANK_NS_3 = 5000000;
	// Retry off-times have no printed figures; plain defaults
	localparam int OFF_NS_0 = 10000000;
	localparam int OFF_NS_1 = 20000000;
	localparam int OFF_NS_2 = 40000000;
	localparam int OFF_NS_3 = 80000000;
	localparam int WAKE_NS = 80000;
	localparam int WAKE_PULSE_NS = 200000;
	localparam int HOLD_NS = 4000000;
	localparam logic [CNT_W-1:0] BLANK_CYC_0 =
		CNT_W'((BLANK_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] BLANK_CYC_1 =
		CNT_W'((BLANK_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] BLANK_CYC_2 =
		CNT_W'((BLANK_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] BLANK_CYC_3 =
		CNT_W'((BLANK_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] OFF_CYC_0 = CNT_W'(OFF_NS_0 / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] OFF_CYC_1 = CNT_W'(OFF_NS_1 / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] OFF_CYC_2 = CNT_W'(OFF_NS_2 / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] OFF_CYC_3 = CNT_W'(OFF_NS_3 / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WAKE_CYC =
		CNT_W'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WAKE_PULSE_CYC =
		CNT_W'(WAKE_PULSE_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] HOLD_CYC =
		CNT_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ------------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_CURRENT_LIMIT = 4'h1;
	localparam logic [3:0] ADDR_ALERT_MASK = 4'h2;
	localparam logic [3:0] ADDR_INTERRUPT = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_MODE = 4'h5;
	localparam int CTL_COMM_EN_BIT = 0;
	localparam int CTL_WAKE_DIS_BIT = 1;
	localparam int CL_SEL_LSB = 0;
	localparam int BL_SEL_LSB = 2;
	localparam int OFF_SEL_LSB = 4;
	localparam int RETRY_BIT = 6;
	// Event, mask and status order: comm, aux, wake, hot warning
	localparam int EV_COMM = 0;
	localparam int EV_AUX = 1;
	localparam int EV_WAKE = 2;
	localparam int EV_HOT = 3;
	localparam int MODE_BUCK_DIS_BIT = 0;
	localparam logic [1:0] CL_SEL_RESET = 2'h0;
	localparam logic [1:0] BL_SEL_RESET = 2'h0;
	localparam logic [1:0] OFF_SEL_RESET = 2'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {LFS_CH_ON, LFS_CH_RETRY_OFF, LFS_CH_HOT_OFF}
		lfs_ch_e;
	typedef enum logic [1:0] {LFS_PG_FAULT, LFS_PG_RUN, LFS_PG_EXT,
		LFS_PG_HOLD} lfs_pg_e;

	typedef struct packed {
		logic [1:0] overcurrent;
		logic [1:0] driver_hot;
		logic [1:0] driver_cool;
		logic field_supply_low;
		logic five_volt_rail_low;
		logic logic_supply_low;
		logic buck_low;
		logic die_warn;
		logic die_shutdown;
		logic five_volt_external;
		logic driver_enable_in;
		logic comm_tx_level;
		logic comm_line_level;
		logic reset_pin_level;
	} lfs_sense_s;

	typedef struct packed {
		logic comm_driver_enable_bit;
		logic wake_detect_disable;
		logic [1:0] current_limit_select;
		logic [1:0] blanking_time_select;
		logic [1:0] retry_off_time_select;
		logic retry_enable;
		logic [3:0] alert_mask_reg;
		logic buck_disable;
	} lfs_regs_s;

	typedef struct packed {
		logic [1:0] drive_on;
		logic [1:0] current_limit_select;
		logic alert_n;
		logic wake_pulse_n;
		logic reset_pin_oe;
		logic regulators_enable;
		logic serial_enable;
		logic [7:0] rdata;
	} lfs_out_s;

	typedef struct packed {
		lfs_sense_s sync1;
		lfs_sense_s sync2;
		lfs_regs_s regs;
		logic [3:0] events;
		lfs_ch_e [1:0] ch_mode;
		logic [1:0][CNT_W-1:0] ch_cnt;
		lfs_pg_e pg;
		logic [CNT_W-1:0] pg_cnt;
		logic [2:0] oe_hist;
		logic tx_prev;
		logic warn_prev;
		logic [CNT_W-1:0] wake_blank;
		logic [CNT_W-1:0] wake_cnt;
		logic [CNT_W-1:0] wake_pulse;
		lfs_out_s out;
	} lfs_state_s;

endpackage

`default_nettype wire

// File: hdl/lfs_top.sv
// Line driver fault supervisor: overcurrent, thermal, wake and power good
`default_nettype none

module lfs_top #(
	parameter logic [3:0][lfs_pkg::CNT_W-1:0] BLANK_CYC = {
		lfs_pkg::BLANK_CYC_3, lfs_pkg::BLANK_CYC_2,
		lfs_pkg::BLANK_CYC_1, lfs_pkg::BLANK_CYC_0},
	parameter logic [3:0][lfs_pkg::CNT_W-1:0] OFF_CYC = {
		lfs_pkg::OFF_CYC_3, lfs_pkg::OFF_CYC_2,
		lfs_pkg::OFF_CYC_1, lfs_pkg::OFF_CYC_0},
	parameter logic [lfs_pkg::CNT_W-1:0] WAKE_PULSE_CYC =
		lfs_pkg::WAKE_PULSE_CYC,
	parameter logic [lfs_pkg::CNT_W-1:0] HOLD_CYC = lfs_pkg::HOLD_CYC
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire lfs_pkg::lfs_sense_s sense,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic comm_drive_on,
	output logic aux_drive_on,
	output logic [1:0] current_limit_select,
	output logic alert_n,
	output logic wake_pulse_n,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	output logic regulators_enable,
	output logic serial_enable
);

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic [1:0] rst_pipe;
	logic rst_sync_b;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end

	assign rst_sync_b = rst_pipe[1];

	// ------------------------------------------------------------------
	// State update
	// ------------------------------------------------------------------
	lfs_pkg::lfs_state_s st;
	lfs_pkg::lfs_state_s next_st;
	lfs_pkg::lfs_sense_s s;
	logic uv_any;
	logic hard_fault;
	logic pin_low;
	logic reg_hold;
	logic serial_ok;
	logic ext_low;
	logic [lfs_pkg::CNT_W-1:0] blank;
	logic [lfs_pkg::CNT_W-1:0] off_time;
	logic [3:0] ev_set;
	logic [3:0] ev_clr;
	logic [3:0] alert_terms;
	logic [1:0] hot_pending;
	logic wake_cond;
	logic [lfs_pkg::CNT_W-1:0] cnt_inc;

	always_comb begin
		next_st = st;
		next_st.sync1 = sense;
		next_st.sync2 = st.sync1;
		s = st.sync2;
		ev_set = 4'h0;
		ev_clr = 4'h0;
		hot_pending = 2'h0;
		cnt_inc = '0;

		uv_any = s.field_supply_low | s.five_volt_rail_low
			| s.logic_supply_low;
		hard_fault = s.field_supply_low | s.five_volt_rail_low
			| s.buck_low | s.die_shutdown;
		pin_low = !s.reset_pin_level;
		// Registers are held during a hard fault and while the pin is low,
		// which covers die shutdown and its exit as well
		reg_hold = pin_low | hard_fault;
		serial_ok = !s.die_shutdown | s.five_volt_external;
		blank = BLANK_CYC[st.regs.blanking_time_select];
		off_time = OFF_CYC[st.regs.retry_off_time_select];

		// --------------------------------------------------------------
		// Power good and reset pin
		// --------------------------------------------------------------
		// Pin reads low for a few cycles after we let go; history of
		// our own drive keeps that from looking like an external reset
		next_st.oe_hist = {st.oe_hist[1:0], st.out.reset_pin_oe};
		ext_low = pin_low && !st.out.reset_pin_oe && st.oe_hist == 3'h0;
		case (st.pg)
			lfs_pkg::LFS_PG_FAULT: begin
				if (!hard_fault) begin
					next_st.pg = lfs_pkg::LFS_PG_RUN;
				end
			end
			lfs_pkg::LFS_PG_RUN: begin
				if (hard_fault) begin
					next_st.pg = lfs_pkg::LFS_PG_FAULT;
				end else if (ext_low) begin
					next_st.pg = lfs_pkg::LFS_PG_EXT;
				end
			end
			lfs_pkg::LFS_PG_EXT: begin
				if (hard_fault) begin
					next_st.pg = lfs_pkg::LFS_PG_FAULT;
				end else if (!pin_low) begin
					next_st.pg_cnt = '0;
					next_st.pg = st.regs.buck_disable ?
						lfs_pkg::LFS_PG_HOLD : lfs_pkg::LFS_PG_RUN;
				end
			end
			lfs_pkg::LFS_PG_HOLD: begin
				if (hard_fault) begin
					next_st.pg = lfs_pkg::LFS_PG_FAULT;
				end else if (!uv_any) begin
					next_st.pg_cnt = st.pg_cnt + 1'b1;
					if (next_st.pg_cnt >= HOLD_CYC) begin
						next_st.pg = lfs_pkg::LFS_PG_RUN;
					end
				end
			end
			default: begin
				next_st.pg = lfs_pkg::LFS_PG_FAULT;
			end
		endcase

		// --------------------------------------------------------------
		// Driver supervision, index 0 comm line, 1 aux line
		// --------------------------------------------------------------
		for (int i = 0; i < 2; i++) begin
			cnt_inc = st.ch_cnt[i] + 1'b1;
			case (st.ch_mode[i])
				lfs_pkg::LFS_CH_ON: begin
					if (s.driver_hot[i]) begin
						next_st.ch_mode[i] = lfs_pkg::LFS_CH_HOT_OFF;
						next_st.ch_cnt[i] = '0;
						ev_set[i] = 1'b1;
					end else if (s.overcurrent[i]) begin
						if (st.ch_cnt[i] < blank) begin
							next_st.ch_cnt[i] = cnt_inc;
							if (cnt_inc == blank) begin
								ev_set[i] = 1'b1;
							end
						end else if (st.regs.retry_enable) begin
							next_st.ch_mode[i] =
								lfs_pkg::LFS_CH_RETRY_OFF;
							next_st.ch_cnt[i] = '0;
						end
					end else begin
						next_st.ch_cnt[i] = '0;
					end
				end
				lfs_pkg::LFS_CH_RETRY_OFF: begin
					if (s.driver_hot[i]) begin
						next_st.ch_mode[i] = lfs_pkg::LFS_CH_HOT_OFF;
						next_st.ch_cnt[i] = '0;
						ev_set[i] = 1'b1;
					end else if (cnt_inc >= off_time) begin
						// Back on for one more blanking window
						next_st.ch_mode[i] = lfs_pkg::LFS_CH_ON;
						next_st.ch_cnt[i] = '0;
					end else begin
						next_st.ch_cnt[i] = cnt_inc;
					end
				end
				lfs_pkg::LFS_CH_HOT_OFF: begin
					if (st.ch_cnt[i] != '1) begin
						next_st.ch_cnt[i] = cnt_inc;
					end
					if (st.regs.retry_enable ? st.ch_cnt[i] >= off_time
						: s.driver_cool[i]) begin
						next_st.ch_mode[i] = lfs_pkg::LFS_CH_ON;
						next_st.ch_cnt[i] = '0;
					end
				end
				default: begin
					next_st.ch_mode[i] = lfs_pkg::LFS_CH_ON;
					next_st.ch_cnt[i] = '0;
				end
			endcase
			// Next state, so the entry cycle cannot leak an alert
			hot_pending[i] = next_st.ch_mode[i] == lfs_pkg::LFS_CH_HOT_OFF
				&& next_st.ch_cnt[i] < blank;
		end

		// --------------------------------------------------------------
		// Wake detection
		// --------------------------------------------------------------
		next_st.tx_prev = s.comm_tx_level;
		if (s.comm_tx_level != st.tx_prev) begin
			next_st.wake_blank = blank;
		end else if (st.wake_blank != '0) begin
			next_st.wake_blank = st.wake_blank - 1'b1;
		end
		wake_cond = st.out.drive_on[0]
			&& s.comm_line_level != s.comm_tx_level
			&& !st.regs.wake_detect_disable
			&& st.wake_blank == '0;
		if (wake_cond) begin
			if (st.wake_cnt < lfs_pkg::WAKE_CYC) begin
				next_st.wake_cnt = st.wake_cnt + 1'b1;
				if (next_st.wake_cnt == lfs_pkg::WAKE_CYC) begin
					next_st.wake_pulse = WAKE_PULSE_CYC;
					ev_set[lfs_pkg::EV_WAKE] = 1'b1;
				end
			end
		end else begin
			next_st.wake_cnt = '0;
		end
		if (st.wake_pulse != '0) begin
			next_st.wake_pulse = st.wake_pulse - 1'b1;
		end

		// --------------------------------------------------------------
		// Die warning
		// --------------------------------------------------------------
		next_st.warn_prev = s.die_warn;
		ev_set[lfs_pkg::EV_HOT] = s.die_warn && !st.warn_prev;

		// --------------------------------------------------------------
		// Register port
		// --------------------------------------------------------------
		next_st.out.rdata = 8'h00;
		if (reg_rd && serial_ok) begin
			case (reg_addr)
				lfs_pkg::ADDR_CONTROL: begin
					next_st.out.rdata[lfs_pkg::CTL_COMM_EN_BIT] =
						st.regs.comm_driver_enable_bit;
					next_st.out.rdata[lfs_pkg::CTL_WAKE_DIS_BIT] =
						st.regs.wake_detect_disable;
				end
				lfs_pkg::ADDR_CURRENT_LIMIT: begin
					next_st.out.rdata[lfs_pkg::CL_SEL_LSB +: 2] =
						st.regs.current_limit_select;
					next_st.out.rdata[lfs_pkg::BL_SEL_LSB +: 2] =
						st.regs.blanking_time_select;
					next_st.out.rdata[lfs_pkg::OFF_SEL_LSB +: 2] =
						st.regs.retry_off_time_select;
					next_st.out.rdata[lfs_pkg::RETRY_BIT] =
						st.regs.retry_enable;
				end
				lfs_pkg::ADDR_ALERT_MASK: begin
					next_st.out.rdata[3:0] = st.regs.alert_mask_reg;
				end
				lfs_pkg::ADDR_INTERRUPT: begin
					next_st.out.rdata[3:0] = st.events;
					ev_clr = 4'hf;
				end
				lfs_pkg::ADDR_STATUS: begin
					for (int i = 0; i < 2; i++) begin
						next_st.out.rdata[i] =
							st.ch_mode[i] == lfs_pkg::LFS_CH_HOT_OFF
							|| (st.ch_mode[i] == lfs_pkg::LFS_CH_ON
							&& s.overcurrent[i]
							&& st.ch_cnt[i] >= blank);
					end
					next_st.out.rdata[lfs_pkg::EV_HOT] = s.die_warn;
				end
				lfs_pkg::ADDR_MODE: begin
					next_st.out.rdata[lfs_pkg::MODE_BUCK_DIS_BIT] =
						st.regs.buck_disable;
				end
				default: begin
					next_st.out.rdata = 8'h00;
				end
			endcase
		end

		if (reg_hold) begin
			// Buck disable survives so the release hold can take effect
			next_st.regs.comm_driver_enable_bit = 1'b0;
			next_st.regs.wake_detect_disable = 1'b0;
			next_st.regs.current_limit_select = lfs_pkg::CL_SEL_RESET;
			next_st.regs.blanking_time_select = lfs_pkg::BL_SEL_RESET;
			next_st.regs.retry_off_time_select = lfs_pkg::OFF_SEL_RESET;
			next_st.regs.retry_enable = 1'b0;
			next_st.regs.alert_mask_reg = lfs_pkg::MASK_RESET;
			next_st.events = 4'h0;
		end else begin
			// Set wins over the clearing read
			next_st.events = (st.events & ~ev_clr) | ev_set;
			if (reg_wr && serial_ok) begin
				case (reg_addr)
					lfs_pkg::ADDR_CONTROL: begin
						next_st.regs.comm_driver_enable_bit =
							reg_wdata[lfs_pkg::CTL_COMM_EN_BIT];
						next_st.regs.wake_detect_disable =
							reg_wdata[lfs_pkg::CTL_WAKE_DIS_BIT];
					end
					lfs_pkg::ADDR_CURRENT_LIMIT: begin
						next_st.regs.current_limit_select =
							reg_wdata[lfs_pkg::CL_SEL_LSB +: 2];
						next_st.regs.blanking_time_select =
							reg_wdata[lfs_pkg::BL_SEL_LSB +: 2];
						next_st.regs.retry_off_time_select =
							reg_wdata[lfs_pkg::OFF_SEL_LSB +: 2];
						next_st.regs.retry_enable =
							reg_wdata[lfs_pkg::RETRY_BIT];
					end
					lfs_pkg::ADDR_ALERT_MASK: begin
						next_st.regs.alert_mask_reg = reg_wdata[3:0];
					end
					default: begin
						next_st.regs = st.regs;
					end
				endcase
			end
		end
		if (reg_wr && serial_ok && reg_addr == lfs_pkg::ADDR_MODE) begin
			next_st.regs.buck_disable =
				reg_wdata[lfs_pkg::MODE_BUCK_DIS_BIT];
		end

		// --------------------------------------------------------------
		// Outputs
		// --------------------------------------------------------------
		for (int i = 0; i < 2; i++) begin
			next_st.out.drive_on[i] =
				next_st.ch_mode[i] == lfs_pkg::LFS_CH_ON
				&& !uv_any && !reg_hold;
		end
		next_st.out.drive_on[0] = next_st.out.drive_on[0]
			&& s.driver_enable_in
			&& st.regs.comm_driver_enable_bit;
		next_st.out.current_limit_select =
			st.regs.current_limit_select;
		alert_terms = next_st.events & ~st.regs.alert_mask_reg;
		alert_terms[1:0] = alert_terms[1:0] & ~hot_pending;
		next_st.out.alert_n = !(|alert_terms);
		next_st.out.wake_pulse_n = next_st.wake_pulse == '0;
		next_st.out.reset_pin_oe = next_st.pg == lfs_pkg::LFS_PG_FAULT
			|| next_st.pg == lfs_pkg::LFS_PG_HOLD;
		next_st.out.regulators_enable = !s.die_shutdown;
		next_st.out.serial_enable = serial_ok;
	end

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st <= '0;
			st.sync1.reset_pin_level <= 1'b1;
			st.sync2.reset_pin_level <= 1'b1;
			st.out.alert_n <= 1'b1;
			st.out.wake_pulse_n <= 1'b1;
			st.out.reset_pin_oe <= 1'b1;
			st.out.regulators_enable <= 1'b1;
			st.out.serial_enable <= 1'b1;
			st.oe_hist <= 3'h7;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.out.rdata;
	assign comm_drive_on = st.out.drive_on[0];
	assign aux_drive_on = st.out.drive_on[1];
	assign current_limit_select = st.out.current_limit_select;
	assign alert_n = st.out.alert_n;
	assign wake_pulse_n = st.out.wake_pulse_n;
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = st.out.reset_pin_oe;
	assign regulators_enable = st.out.regulators_enable;
	assign serial_enable = st.out.serial_enable;

endmodule

`default_nettype wire
